/* obt_transceiver.sv */
// Purpose: octal registered bus transceiver with AXI4-Lite view
// Assumes: MCLK 20 MHz, RST async active high, pins asynchronous
// Notes: every pin passes two flops; ports lag data and control pins by 3 cycles, capture clocks by 4
//   live transfer is therefore not combinational: a bus loop settles
//   only after the lag, and pulses shorter than one cycle may be lost
// Functional notes
// R1: drive B when enabled, A when enable_n low
// R2: each store captures its bus per clock
// R3: capture ignores selects and enables
// R4: select low live, high stored
// R5: A to B live loads both stores
// R6: B to A live loads both stores
// R7: B live drives A lines
// R8: stored B drives A lines
// R9: A live drives B lines
// R10: stored A drives B lines
// R11: both stored directions at once
// R12: both live enabled: buses hold value
// R13: source switch without glitch
// R14: controller staggers clocks when select high
// R15: eight identical channels sharing controls
// R16: stores have no reset
`timescale 1ns/1ns
`default_nettype none
module obt_transceiver
	import obt_pkg::*;
#(
	parameter int W = 8,
	parameter int ADDR_W = 8
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic A_TO_B_DRIVE_ENABLE,
	input wire logic B_TO_A_DRIVE_ENABLE_N,
	input wire logic A_SIDE_CAPTURE_CLOCK,
	input wire logic B_SIDE_CAPTURE_CLOCK,
	input wire logic A_TO_B_SOURCE_SELECT,
	input wire logic B_TO_A_SOURCE_SELECT,
	input wire logic [W-1:0] PORT_A_LINES_I,
	output wire logic [W-1:0] PORT_A_LINES_O,
	output wire logic [W-1:0] PORT_A_LINES_OE,
	input wire logic [W-1:0] PORT_B_LINES_I,
	output wire logic [W-1:0] PORT_B_LINES_O,
	output wire logic [W-1:0] PORT_B_LINES_OE,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	import obt_pkg::*;

	// ====================================================
	// declarations
	localparam int PIN_W = PIN_CTL_W + 2 * W;
	// raw and synchronised pin bundle
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_sync;
	logic [PIN_CTL_W-1:0] ctl_sync;
	logic [W-1:0] a_sync;
	logic [W-1:0] b_sync;
	// edge detector state
	logic clk_a_prev_r;
	logic clk_b_prev_r;
	logic edge_a;
	logic edge_b;
	// software control word and its strobes
	logic [4:0] ctrl_r;
	logic sw_cap_a_r;
	logic sw_cap_b_r;
	// store contents gathered from the channels
	logic [W-1:0] a_store;
	logic [W-1:0] b_store;
	// write channel holding state
	logic aw_full_r;
	logic w_full_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic do_write;
	// decoded indices and read data
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;
	logic [31:0] rd_word;
	logic [31:0] status_word;
	// control bundle fanned out to every channel
	obt_ctl_if ctl ();

	// ====================================================
	// address decode, shared by both bus directions
	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [7:0] a8;
		// a wider address would alias onto its low byte
		a8 = 8'(addr);
		if (a8 == CTRL_OFS) begin
			reg_index = IDX_CTRL;
		end else if (a8 == STATUS_OFS) begin
			reg_index = IDX_STATUS;
		end else if (a8 == STORE_A_OFS) begin
			reg_index = IDX_STORE_A;
		end else if (a8 == STORE_B_OFS) begin
			reg_index = IDX_STORE_B;
		end else begin
			reg_index = IDX_NONE;
		end
	endfunction

	// ====================================================
	// pin synchronisers
	// gather every asynchronous pin into one bundle
	assign pin_raw[PIN_AEN] = A_TO_B_DRIVE_ENABLE;
	// the active-low enable travels inverted, so the synchroniser's reset
	// value of zero means not driving A until the real pin level arrives
	assign pin_raw[PIN_BENN] = ~B_TO_A_DRIVE_ENABLE_N;
	assign pin_raw[PIN_CLKA] = A_SIDE_CAPTURE_CLOCK;
	assign pin_raw[PIN_CLKB] = B_SIDE_CAPTURE_CLOCK;
	assign pin_raw[PIN_ASEL] = A_TO_B_SOURCE_SELECT;
	assign pin_raw[PIN_BSEL] = B_TO_A_SOURCE_SELECT;
	assign pin_raw[PIN_CTL_W +: W] = PORT_A_LINES_I;
	assign pin_raw[PIN_CTL_W + W +: W] = PORT_B_LINES_I;

	// one wide synchroniser keeps data and control in step, so a capture
	// clock and the data it samples cross on the same edge
	obt_sync #(
		.W(PIN_W)
	) u_pin_sync (
		.clk(MCLK),
		.rst(RST),
		.d(pin_raw),
		.q(pin_sync)
	);

	// split the synchronised bundle
	// data lanes sit above the six control lanes
	assign ctl_sync = pin_sync[PIN_CTL_W-1:0];
	assign a_sync = pin_sync[PIN_CTL_W +: W];
	assign b_sync = pin_sync[PIN_CTL_W + W +: W];

	// ====================================================
	// capture clock edge detection
	// previous level of each synchronised capture clock
	// reset value matches the idle low level of the capture clocks,
	// so the release of reset never fakes an edge
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			clk_a_prev_r <= 1'b0;
			clk_b_prev_r <= 1'b0;
		end else begin
			clk_a_prev_r <= ctl_sync[PIN_CLKA];
			clk_b_prev_r <= ctl_sync[PIN_CLKB];
		end
	end

	// R2: rising edge per independent clock
	assign edge_a = ctl_sync[PIN_CLKA] & ~clk_a_prev_r;
	assign edge_b = ctl_sync[PIN_CLKB] & ~clk_b_prev_r;

	// ====================================================
	// effective controls: pins unless software overrides
	// R3: capture independent of selects and enables
	// the override lets software run the ports without pin access
	always_comb begin
		if (ctrl_r[CTRL_OVR_BIT]) begin
			ctl.a_en = ctrl_r[CTRL_AEN_BIT];
			ctl.b_en_n = ctrl_r[CTRL_BENN_BIT];
			ctl.a_sel = ctrl_r[CTRL_ASEL_BIT];
			ctl.b_sel = ctrl_r[CTRL_BSEL_BIT];
		end else begin
			ctl.a_en = ctl_sync[PIN_AEN];
			// the lane holds the enable inverted; undo it here
			ctl.b_en_n = ~ctl_sync[PIN_BENN];
			ctl.a_sel = ctl_sync[PIN_ASEL];
			ctl.b_sel = ctl_sync[PIN_BSEL];
		end
		ctl.cap_a = edge_a | sw_cap_a_r;
		ctl.cap_b = edge_b | sw_cap_b_r;
	end

	// ====================================================
	// bit channels
	// R15: eight identical channels, common controls
	// R5 R6 R7 R8 R9 R10 R11 R12: modes fall out of the mux
	// and enables; the bus input is re-read even while driven,
	// so a live loop re-drives its own last value
	// each channel registers its own mux output; the generate index
	// names the bit, so bit i of A pairs with bit i of B
	for (genvar i = 0; i < W; i++) begin : g_chan
		obt_channel u_chan (
			.clk(MCLK),
			.rst(RST),
			.ctl(ctl),
			.a_in(a_sync[i]),
			.b_in(b_sync[i]),
			.a_out(PORT_A_LINES_O[i]),
			.a_oe(PORT_A_LINES_OE[i]),
			.b_out(PORT_B_LINES_O[i]),
			.b_oe(PORT_B_LINES_OE[i]),
			.a_store(a_store[i]),
			.b_store(b_store[i])
		);
	end

	// ====================================================
	// AXI4-Lite write path
	// address and data are held separately, either order
	// a new write is parked while a response waits, so at most two
	// writes, one awaiting BREADY and one held, are ever in flight
	assign S_AXI_AWREADY = ~aw_full_r;
	assign S_AXI_WREADY = ~w_full_r;
	assign do_write = aw_full_r & w_full_r & ~S_AXI_BVALID;
	assign wr_idx = reg_index(awaddr_r);

	// write address holding register
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			aw_full_r <= 1'b0;
			awaddr_r <= '0;
		end else if (S_AXI_AWVALID && !aw_full_r) begin
			aw_full_r <= 1'b1;
			awaddr_r <= S_AXI_AWADDR;
		end else if (do_write) begin
			aw_full_r <= 1'b0;
		end
	end

	// write data holding register
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			w_full_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (S_AXI_WVALID && !w_full_r) begin
			w_full_r <= 1'b1;
			wdata_r <= S_AXI_WDATA;
			wstrb_r <= S_AXI_WSTRB;
		end else if (do_write) begin
			w_full_r <= 1'b0;
		end
	end

	// write response; unmapped or read-only gives SLVERR
	// the response waits for BREADY; a write that arrives meanwhile
	// stays parked in the holding registers
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= (wr_idx == IDX_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ====================================================
	// control register and software capture pulses
	// only the low byte lane carries control fields
	// the strobe bits are not stored, so they always read back as zero
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ctrl_r <= CTRL_RESET;
		end else if (do_write && wr_idx == IDX_CTRL && wstrb_r[0]) begin
			ctrl_r <= wdata_r[4:0];
		end
	end

	// one-cycle capture strobes, self clearing
	// R2: software strobe acts like a clock edge
	// a strobe in the same cycle as a pin edge is one capture, not
	// two, since both only request the same load
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sw_cap_a_r <= 1'b0;
			sw_cap_b_r <= 1'b0;
		end else begin
			sw_cap_a_r <= do_write && wr_idx == IDX_CTRL && wstrb_r[0] && wdata_r[CTRL_CAPA_BIT];
			sw_cap_b_r <= do_write && wr_idx == IDX_CTRL && wstrb_r[0] && wdata_r[CTRL_CAPB_BIT];
		end
	end

	// ====================================================
	// AXI4-Lite read path
	// ARREADY falls while an answer waits; one read in flight at most
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign rd_idx = reg_index(S_AXI_ARADDR);

	// live state seen by software
	// the drive bits or all lines; the channels share one enable,
	// so any set bit means the whole port is driven
	always_comb begin
		status_word = '0;
		status_word[CTRL_AEN_BIT - 1] = ctl.a_en;
		status_word[CTRL_BENN_BIT - 1] = ctl.b_en_n;
		status_word[CTRL_ASEL_BIT - 1] = ctl.a_sel;
		status_word[CTRL_BSEL_BIT - 1] = ctl.b_sel;
		status_word[STAT_CLKA_BIT] = ctl_sync[PIN_CLKA];
		status_word[STAT_CLKB_BIT] = ctl_sync[PIN_CLKB];
		status_word[STAT_AOE_BIT] = |PORT_A_LINES_OE;
		status_word[STAT_BOE_BIT] = |PORT_B_LINES_OE;
	end

	// read mux; stores read undefined until first capture
	// unmapped addresses fall through to zero and a SLVERR answer
	always_comb begin
		rd_word = '0;
		if (rd_idx == IDX_CTRL) begin
			rd_word[4:0] = ctrl_r;
		end else if (rd_idx == IDX_STATUS) begin
			rd_word = status_word;
		end else if (rd_idx == IDX_STORE_A) begin
			rd_word[W-1:0] = a_store;
		end else if (rd_idx == IDX_STORE_B) begin
			rd_word[W-1:0] = b_store;
		end
	end

	// read data is registered at the address handshake
	// the mux sees the address in the cycle AR is taken, so no
	// address register is needed on this side
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_word;
			S_AXI_RRESP <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* obt_pkg.sv */
// Purpose: shared constants for the octal registered transceiver
// Assumes: one system clock, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
package obt_pkg;
	// ====================================================
	// synchroniser and register map
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] STORE_A_OFS = 8'h08;
	localparam logic [7:0] STORE_B_OFS = 8'h0C;
	// decoded register indices
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_STORE_A = 3'h2;
	localparam logic [2:0] IDX_STORE_B = 3'h3;
	localparam logic [2:0] IDX_NONE = 3'h7;
	// ====================================================
	// control register fields
	localparam int CTRL_OVR_BIT = 0;
	localparam int CTRL_AEN_BIT = 1;
	localparam int CTRL_BENN_BIT = 2;
	localparam int CTRL_ASEL_BIT = 3;
	localparam int CTRL_BSEL_BIT = 4;
	localparam int CTRL_CAPA_BIT = 5;
	localparam int CTRL_CAPB_BIT = 6;
	localparam logic [4:0] CTRL_RESET = 5'h04;
	// ====================================================
	// status register fields
	localparam int STAT_CLKA_BIT = 4;
	localparam int STAT_CLKB_BIT = 5;
	localparam int STAT_AOE_BIT = 6;
	localparam int STAT_BOE_BIT = 7;
	// ====================================================
	// pin bundle positions after synchronising
	localparam int PIN_AEN = 0;
	localparam int PIN_BENN = 1;
	localparam int PIN_CLKA = 2;
	localparam int PIN_CLKB = 3;
	localparam int PIN_ASEL = 4;
	localparam int PIN_BSEL = 5;
	localparam int PIN_CTL_W = 6;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* obt_ctl_if.sv */
// Purpose: control bundle shared by all bit channels
// Assumes: single clock domain
// Notes: one driver, many readers
`timescale 1ns/1ns
`default_nettype none
interface obt_ctl_if;
	logic a_en;
	logic b_en_n;
	logic a_sel;
	logic b_sel;
	logic cap_a;
	logic cap_b;
	modport drive (output a_en, b_en_n, a_sel, b_sel, cap_a, cap_b);
	modport use_side (input a_en, b_en_n, a_sel, b_sel, cap_a, cap_b);
endinterface
`default_nettype wire

/* obt_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module obt_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	// ====================================================
	// double flop, reset to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* obt_channel.sv */
// Purpose: one bit channel: two stores, two muxes, two drivers
// Assumes: inputs already synchronised to clk
// Notes: stores carry no reset on purpose
`timescale 1ns/1ns
`default_nettype none
module obt_channel (
	input wire logic clk,
	input wire logic rst,
	obt_ctl_if.use_side ctl,
	input wire logic a_in,
	input wire logic b_in,
	output logic a_out,
	output logic a_oe,
	output logic b_out,
	output logic b_oe,
	output logic a_store,
	output logic b_store
);
	// ====================================================
	// storage flops
	// R2 R3 R16: capture on every capture request (rising edge or strobe), no reset
	always_ff @(posedge clk) begin
		if (ctl.cap_a) begin
			a_store <= a_in;
		end
		if (ctl.cap_b) begin
			b_store <= b_in;
		end
	end
	// ====================================================
	// registered muxes and drivers; a flop after the mux
	// means a select change cannot glitch the port
	// R1 R4 R13: select live or stored, gate drive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			b_out <= 1'b0;
			b_oe <= 1'b0;
			a_out <= 1'b0;
			a_oe <= 1'b0;
		end else begin
			b_out <= ctl.a_sel ? a_store : a_in;
			b_oe <= ctl.a_en;
			a_out <= ctl.b_sel ? b_store : b_in;
			a_oe <= ~ctl.b_en_n;
		end
	end
endmodule
`default_nettype wire

/* obt_bus_model.sv */
// Purpose: far-side bus for one port of the transceiver
// Assumes: the bench may also drive this bus while the device is on it
// Notes: a line nobody drives drifts to the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module obt_bus_model #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic drv_en,
	input wire logic [W-1:0] drv_val,
	input wire logic [W-1:0] dev_o,
	input wire logic [W-1:0] dev_oe,
	output logic [W-1:0] lvl
);
	logic [W-1:0] last_r;
	// device wins, then our driver; a floating line never shows a stale level
	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl[i] = dev_oe[i] ? dev_o[i] : (drv_en ? drv_val[i] : ~last_r[i]);
		end
	end
	// last resolved level
	always_ff @(posedge clk) begin
		last_r <= lvl;
	end
endmodule
`default_nettype wire

/* obt_transceiver_sva.sv */
// Purpose: port checker for the octal transceiver
// Assumes: pins reach the outputs a few MCLK edges late
// Notes: pin checks wait until pins have been quiet for six edges
`timescale 1ns/1ns
`default_nettype none
module obt_transceiver_chk #(
	parameter int W = 8
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic A_TO_B_DRIVE_ENABLE,
	input wire logic B_TO_A_DRIVE_ENABLE_N,
	input wire logic A_SIDE_CAPTURE_CLOCK,
	input wire logic B_SIDE_CAPTURE_CLOCK,
	input wire logic A_TO_B_SOURCE_SELECT,
	input wire logic B_TO_A_SOURCE_SELECT,
	input wire logic [W-1:0] PORT_A_LINES_I,
	input wire logic [W-1:0] PORT_A_LINES_O,
	input wire logic [W-1:0] PORT_A_LINES_OE,
	input wire logic [W-1:0] PORT_B_LINES_I,
	input wire logic [W-1:0] PORT_B_LINES_O,
	input wire logic [W-1:0] PORT_B_LINES_OE,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA
);
	// ====================
	// quiet-pin helpers: the sync lag makes any earlier look a false alarm
	logic [5:0] pins;
	logic [35:0] hc_r;
	logic [12*W-1:0] hd_r;
	logic [2:0] age_r;
	logic ok, qc, qa;
	assign pins = {B_TO_A_SOURCE_SELECT, A_TO_B_SOURCE_SELECT, B_SIDE_CAPTURE_CLOCK,
		A_SIDE_CAPTURE_CLOCK, B_TO_A_DRIVE_ENABLE_N, A_TO_B_DRIVE_ENABLE};
	assign ok = (age_r == 3'h7);
	assign qc = (hc_r == {6{pins}});
	assign qa = qc && (hd_r == {6{PORT_A_LINES_I, PORT_B_LINES_I}});
	// cycles since reset
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			age_r <= 3'h0;
		end else if (age_r != 3'h7) begin
			age_r <= age_r + 3'h1;
		end
	end
	// pin and bus history
	always_ff @(posedge MCLK) begin
		hc_r <= {hc_r[29:0], pins};
		hd_r <= {hd_r[10*W-1:0], PORT_A_LINES_I, PORT_B_LINES_I};
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	// ====================
	// assertions
	chk_b_oe_pin: assert property (
		ok && qc |-> PORT_B_LINES_OE == {W{A_TO_B_DRIVE_ENABLE}}) else $error("B drive does not follow its enable");
	chk_a_oe_pin: assert property (
		ok && qc |-> PORT_A_LINES_OE == {W{!B_TO_A_DRIVE_ENABLE_N}}) else $error("A drive does not follow its enable");
	chk_oe_whole_port: assert property (
		(PORT_A_LINES_OE == '0 || PORT_A_LINES_OE == '1) && (PORT_B_LINES_OE == '0 || PORT_B_LINES_OE == '1))
		else $error("port drive enables split");
	chk_live_a_b: assert property (
		ok && qa && A_TO_B_DRIVE_ENABLE && !A_TO_B_SOURCE_SELECT |-> PORT_B_LINES_O == PORT_A_LINES_I)
		else $error("B does not carry live A");
	chk_live_b_a: assert property (
		ok && qa && !B_TO_A_DRIVE_ENABLE_N && !B_TO_A_SOURCE_SELECT |-> PORT_A_LINES_O == PORT_B_LINES_I)
		else $error("A does not carry live B");
	chk_stored_b_out: assert property (
		ok && qc && A_TO_B_DRIVE_ENABLE && A_TO_B_SOURCE_SELECT |-> $stable(PORT_B_LINES_O))
		else $error("stored data on B moved without a capture");
	chk_stored_a_out: assert property (
		ok && qc && !B_TO_A_DRIVE_ENABLE_N && B_TO_A_SOURCE_SELECT |-> $stable(PORT_A_LINES_O))
		else $error("stored data on A moved without a capture");
	chk_rdata_held: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
	chk_quiet_after_rst: assert property (
		$fell(RST) |-> (PORT_A_LINES_OE == '0 && PORT_B_LINES_OE == '0) [*3])
		else $error("port driven straight after reset");
	cover property (ok && qc && A_TO_B_DRIVE_ENABLE && !B_TO_A_DRIVE_ENABLE_N);
	cover property ($rose(A_SIDE_CAPTURE_CLOCK) && B_SIDE_CAPTURE_CLOCK == 1'b0);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind obt_transceiver obt_transceiver_chk #(.W(W)) chk_inst (.MCLK(MCLK), .RST(RST),
	.A_TO_B_DRIVE_ENABLE(A_TO_B_DRIVE_ENABLE), .B_TO_A_DRIVE_ENABLE_N(B_TO_A_DRIVE_ENABLE_N),
	.A_SIDE_CAPTURE_CLOCK(A_SIDE_CAPTURE_CLOCK), .B_SIDE_CAPTURE_CLOCK(B_SIDE_CAPTURE_CLOCK),
	.A_TO_B_SOURCE_SELECT(A_TO_B_SOURCE_SELECT), .B_TO_A_SOURCE_SELECT(B_TO_A_SOURCE_SELECT),
	.PORT_A_LINES_I(PORT_A_LINES_I), .PORT_A_LINES_O(PORT_A_LINES_O), .PORT_A_LINES_OE(PORT_A_LINES_OE),
	.PORT_B_LINES_I(PORT_B_LINES_I), .PORT_B_LINES_O(PORT_B_LINES_O), .PORT_B_LINES_OE(PORT_B_LINES_OE),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));
`default_nettype wire

/* obt_transceiver_bench.sv */
// Purpose: directed bench for the octal transceiver
// Assumes: CTRL override stays off except around one status read, so the pins rule the ports
// Notes: stores are seen through the register reads and on the buses in stored-select mode
`timescale 1ns/1ns
`default_nettype none
module obt_transceiver_bench;
	import obt_pkg::*;
	logic mclk, rst, aen, benn, clka, clkb, asel, bsel, ad_en, bd_en;
	logic [7:0] ad_v, bd_v, a_w, b_w, a_o, a_oe, b_o, b_oe, awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [1:0] bresp, rresp;
	int err_count, comparisons;
	obt_transceiver obt_transceiver_inst (.MCLK(mclk), .RST(rst), .A_TO_B_DRIVE_ENABLE(aen),
		.B_TO_A_DRIVE_ENABLE_N(benn), .A_SIDE_CAPTURE_CLOCK(clka), .B_SIDE_CAPTURE_CLOCK(clkb),
		.A_TO_B_SOURCE_SELECT(asel), .B_TO_A_SOURCE_SELECT(bsel), .PORT_A_LINES_I(a_w), .PORT_A_LINES_O(a_o),
		.PORT_A_LINES_OE(a_oe), .PORT_B_LINES_I(b_w), .PORT_B_LINES_O(b_o), .PORT_B_LINES_OE(b_oe),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
	obt_bus_model bus_a_inst (.clk(mclk), .drv_en(ad_en), .drv_val(ad_v), .dev_o(a_o), .dev_oe(a_oe), .lvl(a_w));
	obt_bus_model bus_b_inst (.clk(mclk), .drv_en(bd_en), .drv_val(bd_v), .dev_o(b_o), .dev_oe(b_oe), .lvl(b_w));
	// ====================
	// helpers
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: bus %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic set_pins(input logic e, input logic en_n, input logic s_ab, input logic s_ba);
		aen <= e;
		benn <= en_n;
		asel <= s_ab;
		bsel <= s_ba;
		tick(8);
	endtask
	// pulses last four cycles so the sync never misses them
	task automatic pulse(input logic a, input logic b);
		clka <= a;
		clkb <= b;
		tick(4);
		clka <= 1'b0;
		clkb <= 1'b0;
		tick(8);
	endtask
	task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= ad;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv && n < 100);
		br <= 1'b0;
		cmp32({29'h0, bv, bresp}, {29'h0, 1'b1, er});
	endtask
	// ready is raised a cycle late so the answer has to wait
	task automatic axi_read(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
		int n;
		araddr <= ad;
		arv <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!arr && n < 100);
		arv <= 1'b0;
		@(posedge mclk);
		rr <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (!rv && n < 200);
		rr <= 1'b0;
		cmp32(rdata, ed);
		cmp32({29'h0, rv, rresp}, {29'h0, 1'b1, er});
	endtask
	task automatic stores(input logic [7:0] ea, input logic [7:0] eb);
		axi_read(STORE_A_OFS, {24'h0, ea}, RESP_OKAY);
		axi_read(STORE_B_OFS, {24'h0, eb}, RESP_OKAY);
	endtask
	task automatic stop_test();
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		tick(5000);
		err_count++;
		stop_test();
	end
	// ====================
	// tests
	initial begin
		{rst, aen, clka, clkb, asel, bsel, ad_en, awv, wv, br, arv, rr} = 12'h800;
		{benn, bd_en} = 2'h3;
		{ad_v, bd_v, awaddr, araddr, wdata} = '0;
		tick(3);
		rst <= 1'b0;
		set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		cmp8(a_oe | b_oe, 8'h00);
		axi_read(CTRL_OFS, {27'h0, CTRL_RESET}, RESP_OKAY);
		ad_en <= 1'b1;
		ad_v <= 8'h5A;
		bd_v <= 8'hC3;
		pulse(1'b1, 1'b1);
		stores(8'h5A, 8'hC3);
		ad_v <= 8'h11;
		pulse(1'b1, 1'b0);
		stores(8'h11, 8'hC3);
		bd_en <= 1'b0;
		ad_v <= 8'h66;
		set_pins(1'b1, 1'b1, 1'b0, 1'b0);
		cmp8(b_w, 8'h66);
		cmp8(b_oe & ~a_oe, 8'hFF);
		pulse(1'b1, 1'b1);
		stores(8'h66, 8'h66);
		ad_v <= 8'h99;
		set_pins(1'b1, 1'b1, 1'b1, 1'b0);
		cmp8(b_w, 8'h66);
		ad_en <= 1'b0;
		bd_en <= 1'b1;
		bd_v <= 8'h24;
		set_pins(1'b0, 1'b0, 1'b0, 1'b0);
		cmp8(a_w, 8'h24);
		pulse(1'b1, 1'b1);
		stores(8'h24, 8'h24);
		bd_v <= 8'h81;
		set_pins(1'b0, 1'b0, 1'b0, 1'b1);
		cmp8(a_w, 8'h24);
		set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		ad_en <= 1'b1;
		ad_v <= 8'hA7;
		bd_v <= 8'h3E;
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		ad_en <= 1'b0;
		bd_en <= 1'b0;
		set_pins(1'b1, 1'b0, 1'b1, 1'b1);
		cmp8(b_w, 8'hA7);
		cmp8(a_w, 8'h3E);
		ad_en <= 1'b1;
		ad_v <= 8'h5C;
		set_pins(1'b1, 1'b1, 1'b0, 1'b0);
		set_pins(1'b1, 1'b0, 1'b0, 1'b0);
		ad_en <= 1'b0;
		tick(16);
		cmp8(a_w & b_w, 8'h5C);
		cmp8(a_w | b_w, 8'h5C);
		axi_write(CTRL_OFS, 32'h0000_0064, RESP_OKAY);
		stores(8'h5C, 8'h5C);
		axi_read(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
		axi_write(CTRL_OFS, 32'h0000_001B, RESP_OKAY);
		axi_read(STATUS_OFS, 32'h0000_00CD, RESP_OKAY);
		axi_write(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
		axi_read(STATUS_OFS, 32'h0000_00C1, RESP_OKAY);
		axi_write(STATUS_OFS, 32'h0000_0001, RESP_SLVERR);
		axi_write(8'h40, 32'h0000_0001, RESP_SLVERR);
		axi_read(8'h40, 32'h0, RESP_SLVERR);
		axi_read(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
		stop_test();
	end
endmodule
`default_nettype wire
